/* File: design/sfsp_top.sv */
/*
 Deep sleep entry, wake-up and serial pause control of a SPI flash.
 Serial clock drives the opcode shifter; all other state runs on sys_clk_i.
 Assumes busy_i and the output data come from flash logic on sys_clk_i,
 and chip select rises at least 15 ns after the last serial clock rise.
*/
`timescale 1ns/1ps
module sfsp_top #(
    parameter int unsigned WAKE_CYCLES = sfsp_pkg::SLEEP_EXIT_CYCLES
) (
    input  wire logic  sys_clk_i,
    input  wire logic  resetn_i,
    input  wire logic  sck_i,
    input  wire logic  cs_n_i,
    input  wire logic  si_i,
    input  wire logic  pause_n_i,
    input  wire logic  wp_n_i,
    input  wire logic  busy_i,
    input  wire logic  sdo_i,
    input  wire logic  sdo_en_i,
    output logic       so_o,
    output logic       so_oe_n_o,
    output logic       standby_o,
    output logic       deep_sleep_o,
    output logic       cmd_enable_o,
    output logic       paused_o,
    output logic       cmd_abort_o,
    output logic       write_enable_latch_clear_o,
    output logic       wp_n_o
);
    localparam int ENTRY_BOUND = int'(sfsp_pkg::SLEEP_ENTRY_CYCLES);

    logic                                 rst_n;
    logic [2:0]                           bit_cnt_q;
    logic                                 have_op_q;
    logic [6:0]                           shift_q;
    logic                                 sleep_ok_q;
    logic                                 wake_ok_q;
    logic                                 sleep_hit_q;
    logic                                 wake_hit_q;
    logic [sfsp_pkg::SYNC_W-1:0]          sync_s;
    logic                                 cs_s;
    logic                                 cs_q;
    logic                                 cs_rise;
    logic [1:0]                           sleep_p_q;
    logic [1:0]                           wake_p_q;
    logic                                 paused_q;
    sfsp_pkg::sfsp_state_type             state_q;
    logic [sfsp_pkg::WAKE_CNT_W-1:0]      wake_cnt_q;

    if (WAKE_CYCLES < 1 || WAKE_CYCLES >= (1 << sfsp_pkg::WAKE_CNT_W)) begin : g_bad_wake
        $error("sfsp_top: WAKE_CYCLES out of range");
    end

    // Reset release
    sfsp_sync #(.W(1), .RST_VAL(1'b0)) u_rst_sync (
        .clk_i   (sys_clk_i),
        .rst_n_i (resetn_i),
        .d_i     (1'b1),
        .q_o     (rst_n)
    );

    // Link side: opcode shifter, cleared while chip select is idle
    always_ff @(posedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            bit_cnt_q  <= 3'h0;
            have_op_q  <= 1'b0;
            shift_q    <= 7'h00;
            sleep_ok_q <= 1'b0;
            wake_ok_q  <= 1'b0;
            sleep_hit_q <= 1'b0;
            wake_hit_q <= 1'b0;
        end else if (pause_n_i) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (!have_op_q) begin
                shift_q <= {shift_q[5:0], si_i};
            end
            if (bit_cnt_q == 3'h7 && !have_op_q) begin
                have_op_q   <= 1'b1;
                sleep_hit_q <= ({shift_q, si_i} == sfsp_pkg::SLEEP_OPCODE);
                wake_hit_q  <= ({shift_q, si_i} == sfsp_pkg::WAKE_OPCODE);
                sleep_ok_q  <= ({shift_q, si_i} == sfsp_pkg::SLEEP_OPCODE);
                wake_ok_q   <= ({shift_q, si_i} == sfsp_pkg::WAKE_OPCODE);
            // Valid only on a byte boundary
            end else if (bit_cnt_q == 3'h7) begin
                sleep_ok_q <= sleep_hit_q;
                wake_ok_q  <= wake_hit_q;
            end else begin
                sleep_ok_q <= 1'b0;
                wake_ok_q  <= 1'b0;
            end
        end
    end

    // Link levels into the system clock
    sfsp_sync #(.W(sfsp_pkg::SYNC_W), .RST_VAL(sfsp_pkg::SYNC_RESET)) u_in_sync (
        .clk_i   (sys_clk_i),
        .rst_n_i (rst_n),
        .d_i     ({wake_ok_q, sleep_ok_q, wp_n_i, sck_i, pause_n_i, cs_n_i}),
        .q_o     (sync_s)
    );

    assign cs_s    = sync_s[sfsp_pkg::SYNC_CS];
    assign cs_rise = cs_s && !cs_q;

    // Release edge and aged command flags
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cs_q      <= sfsp_pkg::CS_N_RESET;
            sleep_p_q <= 2'h0;
            wake_p_q  <= 2'h0;
        end else begin
            cs_q      <= cs_s;
            sleep_p_q <= {sleep_p_q[0], sync_s[sfsp_pkg::SYNC_SLEEP_OK]};
            wake_p_q  <= {wake_p_q[0], sync_s[sfsp_pkg::SYNC_WAKE_OK]};
        end
    end

    // Pause state
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            paused_q <= 1'b0;
        end else if (cs_s) begin
            paused_q <= 1'b0;
        end else if (!sync_s[sfsp_pkg::SYNC_SCK]) begin
            paused_q <= !sync_s[sfsp_pkg::SYNC_PAUSE];
        end
    end

    // Power state machine
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_q    <= sfsp_pkg::ST_STANDBY;
            wake_cnt_q <= '0;
        end else begin
            case (state_q)
                sfsp_pkg::ST_STANDBY: begin
                    // Enter sleep on valid release when idle
                    if (cs_rise && sleep_p_q[1] && !busy_i && !paused_q) begin
                        state_q <= sfsp_pkg::ST_SLEEP;
                    end
                end
                sfsp_pkg::ST_SLEEP: begin
                    // Only a complete wake opcode leaves sleep
                    if (cs_rise && wake_p_q[1] && !paused_q) begin
                        state_q    <= sfsp_pkg::ST_WAKING;
                        wake_cnt_q <= '0;
                    end
                end
                sfsp_pkg::ST_WAKING: begin
                    if (wake_cnt_q == sfsp_pkg::WAKE_CNT_W'(WAKE_CYCLES - 1)) begin
                        state_q <= sfsp_pkg::ST_STANDBY;
                    end else begin
                        wake_cnt_q <= wake_cnt_q + 1'b1;
                    end
                end
                default: begin
                    state_q <= sfsp_pkg::ST_STANDBY;
                end
            endcase
        end
    end

    // Status outputs
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            standby_o    <= 1'b1;
            deep_sleep_o <= 1'b0;
            cmd_enable_o <= 1'b0;
            paused_o     <= 1'b0;
            wp_n_o       <= sfsp_pkg::WP_N_RESET;
        end else begin
            // Standby needs idle select and no self-timed cycle
            standby_o    <= (state_q == sfsp_pkg::ST_STANDBY) && cs_s && !busy_i;
            deep_sleep_o <= (state_q == sfsp_pkg::ST_SLEEP);
            cmd_enable_o <= (state_q == sfsp_pkg::ST_STANDBY) && !paused_q;
            paused_o     <= paused_q;
            wp_n_o       <= sync_s[sfsp_pkg::SYNC_WP];
        end
    end

    // Abort and latch clear on release during pause
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cmd_abort_o <= 1'b0;
            write_enable_latch_clear_o <= 1'b0;
        end else begin
            cmd_abort_o <= cs_rise && paused_q;
            write_enable_latch_clear_o <= cs_rise && paused_q;
        end
    end

    // Serial data output
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            so_o      <= 1'b0;
            so_oe_n_o <= sfsp_pkg::SO_OE_N_RESET;
        end else begin
            so_o      <= sdo_i;
            // Output floats while paused or asleep
            so_oe_n_o <= !(sdo_en_i && !paused_q && !cs_s
                           && state_q == sfsp_pkg::ST_STANDBY);
        end
    end

    sequence s_release_paused;
        cs_rise && paused_q;
    endsequence

    sequence s_latch_pulse;
        write_enable_latch_clear_o && cmd_abort_o ##1 !write_enable_latch_clear_o;
    endsequence

    sequence s_valid_sleep;
        cs_rise && sleep_p_q[1] && !busy_i && !paused_q
            && state_q == sfsp_pkg::ST_STANDBY;
    endsequence

    a_sleep_entry_time: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        s_valid_sleep |-> ##[1:ENTRY_BOUND] deep_sleep_o)
        else $error("deep sleep not reached in time");

    a_busy_blocks_sleep: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        state_q == sfsp_pkg::ST_STANDBY && busy_i |=> state_q != sfsp_pkg::ST_SLEEP)
        else $error("sleep entered during busy cycle");

    a_sleep_ignores_other: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        state_q == sfsp_pkg::ST_SLEEP && !(cs_rise && wake_p_q[1])
            |=> state_q == sfsp_pkg::ST_SLEEP)
        else $error("sleep left without wake command");

    a_wake_count_bound: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        state_q == sfsp_pkg::ST_WAKING |-> wake_cnt_q < WAKE_CYCLES)
        else $error("wake count beyond exit time");

    a_sleep_cmd_block: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        state_q != sfsp_pkg::ST_STANDBY |=> !cmd_enable_o && so_oe_n_o)
        else $error("commands enabled while asleep");

    a_pause_needs_select: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        cs_s [*2] |=> !paused_o)
        else $error("pause shown without chip select");

    a_pause_high_phase: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        !paused_q && !cs_s && sync_s[sfsp_pkg::SYNC_SCK] |=> !paused_q)
        else $error("pause started in clock-high phase");

    a_pause_floats_out: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        paused_q |=> so_oe_n_o && paused_o)
        else $error("output driven while paused");

    a_release_clears_latch: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        s_release_paused |=> s_latch_pulse)
        else $error("latch clear pulse missing");

    a_link_pause_count: assert property (
        @(posedge sck_i) disable iff (cs_n_i)
        !pause_n_i |=> $stable(bit_cnt_q))
        else $error("bit count moved while paused");
endmodule // sfsp_top

/* File: design/sfsp_pkg.sv */
/*
 Constants for the flash sleep and pause control block.
 Assumes a 200 MHz system clock and an SPI mode 0 or 3 serial link.
*/
package sfsp_pkg;
    // Opcodes
    localparam logic [7:0] SLEEP_OPCODE     = 8'hb9;
    localparam logic [7:0] WAKE_OPCODE      = 8'hab;
    localparam int unsigned OPCODE_BITS     = 8;
    // Timing
    localparam int unsigned SYS_CLK_MHZ     = 200;
    localparam int unsigned SLEEP_ENTRY_TIME_NS = 1;
    localparam int unsigned SLEEP_ENTRY_SCALE   = 1000;
    localparam int unsigned SLEEP_EXIT_TIME_US  = 30;
    // Longest times round down
    localparam int unsigned SLEEP_ENTRY_CYCLES =
        (SLEEP_ENTRY_TIME_NS * SLEEP_ENTRY_SCALE * SYS_CLK_MHZ) / 1000;
    localparam int unsigned SLEEP_EXIT_CYCLES  = SLEEP_EXIT_TIME_US * SYS_CLK_MHZ;
    localparam int unsigned WAKE_CNT_W         = 16;
    // Reset values
    localparam logic        CS_N_RESET      = 1'b1;
    localparam logic        PAUSE_N_RESET   = 1'b1;
    localparam logic        WP_N_RESET      = 1'b1;
    localparam logic        SO_OE_N_RESET   = 1'b1;
    // Synchroniser bit positions
    localparam int unsigned SYNC_CS         = 0;
    localparam int unsigned SYNC_PAUSE      = 1;
    localparam int unsigned SYNC_SCK        = 2;
    localparam int unsigned SYNC_WP         = 3;
    localparam int unsigned SYNC_SLEEP_OK   = 4;
    localparam int unsigned SYNC_WAKE_OK    = 5;
    localparam int unsigned SYNC_W          = 6;
    localparam logic [SYNC_W-1:0] SYNC_RESET = 6'h0b;

    typedef enum logic [1:0] {
        ST_STANDBY,
        ST_SLEEP,
        ST_WAKING
    } sfsp_state_type;
endpackage

/* File: design/sfsp_sync.sv */
/*
 Two flip-flop synchroniser for a group of independent levels.
 Assumes each bit is a level that changes far slower than the clock.
*/
`timescale 1ns/1ps
module sfsp_sync #(
    parameter int unsigned      W       = 1,
    parameter logic [W-1:0]     RST_VAL = '0
) (
    input  wire logic           clk_i,
    input  wire logic           rst_n_i,
    input  wire logic [W-1:0]   d_i,
    output logic      [W-1:0]   q_o
);
    logic [W-1:0] meta_q;

    if (W < 1) begin : g_bad_width
        $error("sfsp_sync: W must be at least 1");
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= RST_VAL;
            q_o    <= RST_VAL;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end
endmodule // sfsp_sync

/* File: verif/sfsp_host.sv */
/*
 Host side model of the serial link: chip select, clock, data and pause pin.
 Assumes a mode 0 link at 48 ns period; clock stands low outside frames.
*/
`timescale 1ns/1ps
module sfsp_host (
    output logic sck_o,
    output logic cs_n_o,
    output logic si_o,
    output logic pause_n_o
);
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
        pause_n_o = 1'b1;
    end

    task automatic clk_bit(input logic b);
        si_o = b;
        #24 sck_o = 1'b1;
        #24 sck_o = 1'b0;
    endtask

    task automatic frame(input logic [15:0] d, input int n, input int pat, input int plen,
                         input bit hold_end);
        cs_n_o = 1'b0;
        #24;
        for (int i = 0; i <= n; i++) begin
            if (i == pat) begin
                pause_n_o = 1'b0;
                for (int k = 0; k < plen; k++) clk_bit(~si_o);
                if (!hold_end) #4 pause_n_o = 1'b1;
            end
            if (i < n) clk_bit(d[15-i]);
        end
        #24 cs_n_o = 1'b1;
        si_o = ~si_o;
        #12 pause_n_o = 1'b1;
        #48;
    endtask

    task automatic idle_pause();
        pause_n_o = 1'b0;
        #200 pause_n_o = 1'b1;
        #50;
    endtask
endmodule // sfsp_host

/* File: verif/spi_flash_sleep_and_pause_bench.sv */
/*
 Self-checking bench for deep sleep entry, wake-up and pause control.
 Assumes the host model drives the link and the bench drives the core side.
*/
`timescale 1ns/1ps
module spi_flash_sleep_and_pause_bench;
    localparam int unsigned WAKE_N = 20;
    logic sys_clk_i, resetn_i, sck_i, cs_n_i, si_i, pause_n_i;
    logic wp_n_i, busy_i, sdo_i, sdo_en_i, prev_p;
    logic so_o, so_oe_n_o, standby_o, deep_sleep_o, cmd_enable_o;
    logic paused_o, cmd_abort_o, write_enable_latch_clear_o, wp_n_o;
    int   num_errors = 0;
    int   check_count = 0;
    int   seen_paused, abort_cnt, latch_mis, oe_mis;

    sfsp_host u_host (.sck_o(sck_i), .cs_n_o(cs_n_i), .si_o(si_i), .pause_n_o(pause_n_i));

    sfsp_top #(.WAKE_CYCLES(WAKE_N)) u_dut (
        .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .sck_i(sck_i), .cs_n_i(cs_n_i),
        .si_i(si_i), .pause_n_i(pause_n_i), .wp_n_i(wp_n_i), .busy_i(busy_i),
        .sdo_i(sdo_i), .sdo_en_i(sdo_en_i), .so_o(so_o), .so_oe_n_o(so_oe_n_o),
        .standby_o(standby_o), .deep_sleep_o(deep_sleep_o), .cmd_enable_o(cmd_enable_o),
        .paused_o(paused_o), .cmd_abort_o(cmd_abort_o),
        .write_enable_latch_clear_o(write_enable_latch_clear_o),
        .wp_n_o(wp_n_o));

    initial begin
        sys_clk_i = 1'b0;
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end

    always @(posedge sys_clk_i) begin
        if (paused_o === 1'b1) seen_paused++;
        if (cmd_abort_o === 1'b1) abort_cnt++;
        if (cmd_abort_o !== write_enable_latch_clear_o) latch_mis++;
        if (prev_p === 1'b1 && paused_o === 1'b1 && so_oe_n_o !== 1'b1) oe_mis++;
        prev_p = paused_o;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask

    task automatic wait_for(input logic d, input logic s, input int lim);
        for (int i = 0; i < lim && (deep_sleep_o !== d || standby_o !== s); i++) step(1);
    endtask

    task automatic clr();
        seen_paused = 0;
        abort_cnt = 0;
        latch_mis = 0;
        oe_mis = 0;
    endtask

    task automatic end_of_test();
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic s_reset();
        chk("standby_o", 1, standby_o);
        chk("deep_sleep_o", 0, deep_sleep_o);
        chk("cmd_enable_o", 1, cmd_enable_o);
    endtask

    task automatic s_output();
        sdo_en_i = 1'b1;
        sdo_i = 1'b1;
        fork
            u_host.frame(16'h0500, 8, -1, 0, 1'b0);
            begin
                step(12);
                chk("so_o", 1, so_o);
                chk("so_oe_n_o selected", 0, so_oe_n_o);
            end
        join
        step(2);
        chk("so_oe_n_o idle", 1, so_oe_n_o);
    endtask

    task automatic s_power_cycle();
        u_host.frame(16'hb900, 8, -1, 0, 1'b0);
        step(1);
        chk("deep_sleep_o", 1, deep_sleep_o);
        resetn_i = 1'b0;
        step(3);
        resetn_i = 1'b1;
        step(6);
        chk("standby_o", 1, standby_o);
        chk("deep_sleep_o", 0, deep_sleep_o);
    endtask

    task automatic s_misaligned();
        int lens [2] = '{7, 12};
        foreach (lens[i]) begin
            u_host.frame(16'hb9f0, lens[i], -1, 0, 1'b0);
            step(2);
            chk("deep_sleep_o", 0, deep_sleep_o);
            chk("standby_o", 1, standby_o);
        end
    endtask

    task automatic s_busy();
        busy_i = 1'b1;
        u_host.frame(16'hb900, 8, -1, 0, 1'b0);
        step(2);
        chk("deep_sleep_o", 0, deep_sleep_o);
        chk("standby_o", 0, standby_o);
        busy_i = 1'b0;
        step(3);
        chk("standby_o", 1, standby_o);
    endtask

    task automatic s_wake();
        u_host.frame(16'hab00, 8, -1, 0, 1'b0);
        wait_for(1'b0, 1'b1, WAKE_N - 4);
        chk("standby_o", 1, standby_o);
        chk("deep_sleep_o", 0, deep_sleep_o);
        chk("cmd_enable_o", 1, cmd_enable_o);
    endtask

    task automatic s_sleep();
        u_host.frame(16'hb95a, 16, -1, 0, 1'b0);
        step(1);
        chk("deep_sleep_o", 1, deep_sleep_o);
        chk("standby_o", 0, standby_o);
        u_host.frame(16'h0500, 8, -1, 0, 1'b0);
        step(2);
        chk("deep_sleep_o", 1, deep_sleep_o);
        chk("cmd_enable_o", 0, cmd_enable_o);
        chk("so_oe_n_o", 1, so_oe_n_o);
        u_host.frame(16'hab00, 4, -1, 0, 1'b0);
        step(2);
        chk("deep_sleep_o", 1, deep_sleep_o);
        s_wake();
    endtask

    task automatic s_pause_mid();
        clr();
        fork
            u_host.frame(16'hb900, 8, 4, 6, 1'b0);
            begin
                step(63);
                wp_n_i = 1'b0;
                step(8);
                chk("wp_n_o", 0, wp_n_o);
                chk("paused_o", 1, paused_o);
                wp_n_i = 1'b1;
            end
        join
        step(1);
        chk("deep_sleep_o", 1, deep_sleep_o);
        chk("paused seen", 1, seen_paused > 0);
        chk("so_oe_n_o paused", 0, oe_mis);
        s_wake();
    endtask

    task automatic s_pause_abort();
        clr();
        u_host.frame(16'hb900, 8, 8, 6, 1'b1);
        step(4);
        chk("deep_sleep_o", 0, deep_sleep_o);
        chk("standby_o", 1, standby_o);
        chk("cmd_abort_o pulses", 1, abort_cnt);
        chk("write_enable_latch_clear_o pairing", 0, latch_mis);
    endtask

    task automatic s_pause_idle();
        clr();
        u_host.idle_pause();
        step(2);
        chk("paused seen", 0, seen_paused);
    endtask

    initial begin
        #200000;
        num_errors++;
        $display("CHECK FAILED watchdog expected done seen timeout");
        end_of_test();
    end

    initial begin
        resetn_i = 1'b0;
        wp_n_i = 1'b1;
        busy_i = 1'b0;
        sdo_i = 1'b0;
        sdo_en_i = 1'b0;
        repeat (20) @(posedge sys_clk_i);
        #1 resetn_i = 1'b1;
        step(6);
        s_reset();
        s_output();
        s_misaligned();
        s_busy();
        s_sleep();
        s_pause_mid();
        s_pause_abort();
        s_pause_idle();
        s_power_cycle();
        end_of_test();
    end
endmodule // spi_flash_sleep_and_pause_bench
